// ---- dlca_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module dlca_checker #(
  parameter int STRAP_WAIT = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_down_release_pin,
  input wire logic [1:0] link_pair_out,
  input wire logic [1:0] link_pair_oe,
  input wire logic relay_valid,
  input wire logic relay_port,
  input wire logic [1:0] relay_ready,
  input wire logic [1:0] fwd_ctrl_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic [1:0] tx_vc,
  input wire logic tx_last,
  input wire logic tx_dual,
  input wire logic tx_clk_b_en,
  input wire logic tx_b_valid,
  input wire logic tx_b_ready,
  input wire logic [31:0] tx_b_data,
  input wire logic [1:0] tx_b_vc,
  input wire logic tx_b_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_clkb_dual: assert property (
    tx_clk_b_en == tx_dual) else $error("clock lane b mismatch");
  chk_single_quiet: assert property (
    !tx_dual |-> !tx_b_valid) else $error("replica active in single");
  chk_replica_same: assert property (
    tx_dual && tx_valid |-> tx_b_valid && tx_b_data == tx_data
      && tx_b_vc == tx_vc && tx_b_last == tx_last)
    else $error("replica differs");
  chk_tx_hold: assert property (
    tx_valid && !(tx_ready && (tx_b_ready || !tx_dual)) |=> tx_valid
      && $stable(tx_data) && $stable(tx_vc) && $stable(tx_last))
    else $error("output word dropped while stalled");
  chk_boot_wait: assert property (
    $rose(link_pair_oe[0]) |-> $past(power_down_release_pin, STRAP_WAIT))
    else $error("driver enabled too early");
  chk_relay_run: assert property (
    relay_ready[1] |-> link_pair_oe[1]) else $error("ready before run");
  chk_relay_take: assert property (
    relay_valid && !relay_port && relay_ready[0] |=> !relay_ready[0])
    else $error("relay byte not taken");
  chk_rev_alive: assert property (
    link_pair_oe[0] && !link_pair_out[0] |-> ##[1:260] link_pair_out[0])
    else $error("reverse channel stalled");
  chk_ctrl_pulse: assert property (
    fwd_ctrl_valid[0] |=> !fwd_ctrl_valid[0] [*8])
    else $error("frame pulse too long");
endmodule : dlca_checker
bind dlca_top dlca_checker #(.STRAP_WAIT(STRAP_WAIT)) i_chk (
  .clk(clk), .arst_n(arst_n),
  .power_down_release_pin(power_down_release_pin),
  .link_pair_out(link_pair_out), .link_pair_oe(link_pair_oe),
  .relay_valid(relay_valid), .relay_port(relay_port),
  .relay_ready(relay_ready), .fwd_ctrl_valid(fwd_ctrl_valid),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_vc(tx_vc), .tx_last(tx_last), .tx_dual(tx_dual),
  .tx_clk_b_en(tx_clk_b_en), .tx_b_valid(tx_b_valid),
  .tx_b_ready(tx_b_ready), .tx_b_data(tx_b_data), .tx_b_vc(tx_b_vc),
  .tx_b_last(tx_b_last));
`default_nettype wire

// ---- dlca_buf2.sv ----
`timescale 1ns/1ns
`default_nettype none
module dlca_buf2 #(
  parameter int W = 35
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [0:1];
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop) cnt_reg <= cnt_reg + 2'h1;
      else if (pop && !push) cnt_reg <= cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule : dlca_buf2
`default_nettype wire

// ---- dlca_pkg.sv ----
package dlca_pkg;
  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] DLCA_OFS_PORT_CFG = 8'h6D;
  localparam logic [7:0] DLCA_OFS_DEV_CTRL = 8'h20;
  localparam logic [7:0] DLCA_OFS_STATUS = 8'h21;
  localparam logic [7:0] DLCA_OFS_VC_MAP0 = 8'h30;
  localparam logic [7:0] DLCA_OFS_VC_MAP1 = 8'h31;
  localparam logic [7:0] DLCA_PORT_CFG_RST = 8'h00;
  localparam logic [7:0] DLCA_DEV_CTRL_RST = 8'h00;
  localparam logic [7:0] DLCA_VC_MAP0_RST = 8'hE4;
  localparam logic [7:0] DLCA_VC_MAP1_RST = 8'hE4;
  localparam int DLCA_MODE_LSB = 0;
  localparam int DLCA_CTRL_DUAL = 0;
  localparam int DLCA_CTRL_SYNC = 1;
  localparam int DLCA_ST_REF_EXT = 0;
  localparam int DLCA_ST_STRAP = 1;
  localparam int DLCA_ST_PERR = 2;
  localparam int DLCA_ST_OVF = 4;
  // ********************************************************
  // input modes
  // ********************************************************
  localparam logic [1:0] DLCA_MODE_CSI = 2'h0;
  localparam logic [1:0] DLCA_MODE_RAW12LF = 2'h1;
  localparam logic [1:0] DLCA_MODE_RAW12HF = 2'h2;
  localparam logic [1:0] DLCA_MODE_RAW10 = 2'h3;
  localparam logic [2:0] DLCA_STRAP_CSI_ASYNC = 3'h0;
  localparam logic [2:0] DLCA_STRAP_CSI_SYNC = 3'h4;
  // ********************************************************
  // link frames
  // ********************************************************
  localparam logic [5:0] DLCA_CSI_FRAME_LEN = 6'd40;
  localparam logic [5:0] DLCA_RAW_FRAME_LEN = 6'd28;
  localparam int DLCA_WORD_W = 35;
  localparam int DLCA_BC_LEN = 10;
  // ********************************************************
  // rates and times
  // ********************************************************
  localparam int DLCA_LINE_PER_REF = 160;
  localparam int DLCA_PCLK_PER_REF = 4;
  localparam int DLCA_BC_PER_REF = 2;
  localparam int DLCA_LINE_PER_EXT = 80;
  localparam int DLCA_MAX_LINE_MBPS = 4160;
  localparam int DLCA_MAX_SENSOR_MBPS = 3328;
  localparam int DLCA_MAX_LANE_MBPS = 1662;
  localparam int DLCA_CLK_MHZ = 250;
  localparam int DLCA_CLK_NS = 4;
  localparam int DLCA_BC_ASYNC_MBPS = 10;
  localparam int DLCA_BC_ASYNC_CYC = DLCA_CLK_MHZ / DLCA_BC_ASYNC_MBPS;
  localparam int DLCA_OSC_MHZ = 25;
  localparam int DLCA_OSC_HALF_CYC = DLCA_CLK_MHZ / (2 * DLCA_OSC_MHZ);
  localparam int DLCA_STRAP_WAIT_NS = 1000000;
  localparam int DLCA_STRAP_WAIT_CYC = DLCA_STRAP_WAIT_NS / DLCA_CLK_NS;
  localparam int DLCA_REF_LOSS_NS = 20000;
  localparam int DLCA_REF_LOSS_CYC = DLCA_REF_LOSS_NS / DLCA_CLK_NS;
endpackage : dlca_pkg

// ---- dlca_ser_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ********************************************************
// remote serializer: one forward link, bit clock 64 ns
// ********************************************************
module dlca_ser_model (
  output logic lclk,
  output logic ldat,
  output logic lfrm
);
  initial begin
    lclk = 1'b0;
    ldat = 1'b0;
    lfrm = 1'b0;
  end
  // clock stands still between frames; data shows no stale bit after
  task automatic send(input logic [39:0] w, input int len);
    #1;
    for (int i = len - 1; i >= 0; i--) begin
      ldat = w[i];
      lfrm = (i == len - 1);
      #32 lclk = 1'b1;
      #32 lclk = 1'b0;
    end
    ldat = ~ldat;
    lfrm = 1'b0;
  endtask : send
endmodule : dlca_ser_model
`default_nettype wire

// ---- dlca_top.sv ----
// How it works
// - output is one four-lane port or two replicated two-lane ports
// - dual output mode enables a second clock lane
// - payload forwarded unchanged, no format conversion
// - only frames with good parity and their flag bit set reach the csi output; any good-parity packet frame still forwards its control bits
// - each stream carries its virtual channel in the header
// - packet mode deframes fixed 40-bit link frames
// - raw mode deframes fixed 28-bit link frames at lower rate
// - device drives reverse control channel on the video pair
// - control channel runs continuously, never waits for blanking
// - host control traffic is relayed over the link
// - two independent receive ports work at the same time
// - each port picks its mode; output is always the csi port
// - input mode from two-bit config field or mode strap
// - packet mode has synchronous and non-synchronous clocking
// - each port remaps incoming virtual channel ids
// - packet mode line rate up to the stated maximum
// - sync clocking: line 160x, pixel 4x, back channel 2x ref
// - sensor csi rate independent of line and output rates
// - non-sync clocking: back channel at fixed 10 Mbps
// - forward line rate independent of output csi rate
// - strap sampled 1 ms after power-down release
// - internal 25 MHz reference used until ref clock is valid
`timescale 1ns/1ns
`default_nettype none
module dlca_top
  import dlca_pkg::*;
#(
  parameter int STRAP_WAIT = DLCA_STRAP_WAIT_CYC,
  parameter int REF_LOSS = DLCA_REF_LOSS_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic power_down_release_pin,
  input wire logic [2:0] mode_strap,
  input wire logic ref_clock_input,
  input wire logic [1:0] link_clk,
  input wire logic [1:0] link_data,
  input wire logic [1:0] link_frame,
  output logic [1:0] link_pair_out,
  output logic [1:0] link_pair_oe,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_port_sel,
  output logic [7:0] reg_rdata,
  input wire logic relay_valid,
  input wire logic relay_port,
  input wire logic [7:0] relay_data,
  output logic [1:0] relay_ready,
  output logic [1:0] fwd_ctrl_valid,
  output logic [5:0] fwd_ctrl_bits,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic [1:0] tx_vc,
  output logic tx_last,
  output logic tx_src_port,
  output logic tx_dual,
  output logic tx_clk_b_en,
  output logic tx_b_valid,
  input wire logic tx_b_ready,
  output logic [31:0] tx_b_data,
  output logic [1:0] tx_b_vc,
  output logic tx_b_last
);
  typedef enum logic [1:0] {
    DLCA_PD = 2'b00, DLCA_WAIT = 2'b01, DLCA_RUN = 2'b11
  } dlca_boot_t;
  typedef enum logic [1:0] {
    DLCA_ARB_IDLE = 2'b00, DLCA_ARB_P0 = 2'b01, DLCA_ARB_P1 = 2'b11
  } dlca_arb_t;

  function automatic logic [1:0] dlca_remap(input logic [7:0] map,
                                            input logic [1:0] vc);
    dlca_remap = map[{vc, 1'b0} +: 2];
  endfunction : dlca_remap

  function automatic logic dlca_is_raw(input logic [1:0] mode);
    dlca_is_raw = (mode != DLCA_MODE_CSI);
  endfunction : dlca_is_raw

  logic [7:0] port_cfg_reg [0:1];
  logic [7:0] vc_map_reg [0:1];
  logic [7:0] dev_ctrl_reg;
  logic [1:0] perr_reg;
  logic [1:0] ovf_reg;
  logic ref_ext_reg;
  dlca_boot_t boot_reg;
  logic [17:0] boot_cnt_reg;
  logic pdr_s1_reg, pdr_s2_reg;
  logic [2:0] st_s1_reg, st_s2_reg;
  logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
  logic [12:0] ref_idle_reg;
  logic [2:0] osc_cnt_reg;
  logic ref_tick;
  logic osc_tick;
  logic [4:0] bc_div_reg;
  logic bc_tick;
  logic [1:0] frm_push;
  logic [1:0] frm_ready;
  logic [DLCA_WORD_W-1:0] frm_word [0:1];
  logic [1:0] q_valid;
  logic [1:0] q_pop;
  logic [DLCA_WORD_W-1:0] q_word [0:1];
  logic [1:0] bad_par;
  logic [1:0] pend_reg;
  logic [7:0] pend_byte_reg [0:1];
  dlca_arb_t arb_reg;
  logic last_grant_reg;
  logic pick;
  logic load;
  logic out_free;

  // ********************************************************
  // power-up strap capture and reference selection
  // ********************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pdr_s1_reg <= 1'b0;
      pdr_s2_reg <= 1'b0;
      {st_s1_reg, st_s2_reg} <= 6'h00;
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end else begin
      pdr_s1_reg <= power_down_release_pin;
      pdr_s2_reg <= pdr_s1_reg;
      st_s1_reg <= mode_strap;
      st_s2_reg <= st_s1_reg;
      ref_s1_reg <= ref_clock_input;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  // strap pins settle during the wait; only sampled when it expires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_reg <= DLCA_PD;
      boot_cnt_reg <= 18'h00000;
    end else begin
      case (boot_reg)
        DLCA_PD: begin
          boot_cnt_reg <= 18'h00000;
          if (pdr_s2_reg) boot_reg <= DLCA_WAIT;
        end
        DLCA_WAIT: begin
          boot_cnt_reg <= boot_cnt_reg + 18'h00001;
          if (!pdr_s2_reg) boot_reg <= DLCA_PD;
          else if (boot_cnt_reg == 18'(STRAP_WAIT - 1))
            boot_reg <= DLCA_RUN;
        end
        DLCA_RUN: if (!pdr_s2_reg) boot_reg <= DLCA_PD;
        default: boot_reg <= DLCA_PD;
      endcase
    end
  end

  // any ref edge counts; a silent ref reverts to the internal source
  assign ref_tick = ref_s2_reg ^ ref_s3_reg;
  assign osc_tick = (osc_cnt_reg == 3'(DLCA_OSC_HALF_CYC - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_idle_reg <= 13'h0000;
      ref_ext_reg <= 1'b0;
      osc_cnt_reg <= 3'h0;
    end else begin
      osc_cnt_reg <= osc_tick ? 3'h0 : osc_cnt_reg + 3'h1;
      if (ref_tick) begin
        ref_idle_reg <= 13'h0000;
        ref_ext_reg <= 1'b1;
      end else if (ref_idle_reg == 13'(REF_LOSS - 1)) begin
        ref_ext_reg <= 1'b0;
      end else begin
        ref_idle_reg <= ref_idle_reg + 13'h0001;
      end
    end
  end

  // back channel bit clock: twice the reference when synchronous,
  // a fixed divider otherwise; forward rates never feed into it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bc_div_reg <= 5'h00;
    end else if (bc_div_reg == 5'(DLCA_BC_ASYNC_CYC - 1)) begin
      bc_div_reg <= 5'h00;
    end else begin
      bc_div_reg <= bc_div_reg + 5'h01;
    end
  end
  assign bc_tick = dev_ctrl_reg[DLCA_CTRL_SYNC]
    ? (ref_ext_reg ? ref_tick : osc_tick)
    : (bc_div_reg == 5'h00);

  // ********************************************************
  // register port
  // ********************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_cfg_reg[0] <= DLCA_PORT_CFG_RST;
      port_cfg_reg[1] <= DLCA_PORT_CFG_RST;
      vc_map_reg[0] <= DLCA_VC_MAP0_RST;
      vc_map_reg[1] <= DLCA_VC_MAP1_RST;
      dev_ctrl_reg <= DLCA_DEV_CTRL_RST;
    end else if (boot_reg == DLCA_WAIT &&
                 boot_cnt_reg == 18'(STRAP_WAIT - 1)) begin
      // strap applies to both ports; software may override later
      port_cfg_reg[0][1:0] <= (st_s2_reg == DLCA_STRAP_CSI_SYNC)
        ? DLCA_MODE_CSI : st_s2_reg[1:0];
      port_cfg_reg[1][1:0] <= (st_s2_reg == DLCA_STRAP_CSI_SYNC)
        ? DLCA_MODE_CSI : st_s2_reg[1:0];
      dev_ctrl_reg[DLCA_CTRL_SYNC] <=
        (st_s2_reg == DLCA_STRAP_CSI_SYNC);
    end else if (reg_wr) begin
      case (reg_addr)
        DLCA_OFS_PORT_CFG: port_cfg_reg[reg_port_sel] <= reg_wdata;
        DLCA_OFS_DEV_CTRL: dev_ctrl_reg <= reg_wdata;
        DLCA_OFS_VC_MAP0: vc_map_reg[0] <= reg_wdata;
        DLCA_OFS_VC_MAP1: vc_map_reg[1] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // sticky errors: write one to clear, a new event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      perr_reg <= 2'h0;
      ovf_reg <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == DLCA_OFS_STATUS) begin
        perr_reg <= (perr_reg & ~reg_wdata[DLCA_ST_PERR +: 2]) | bad_par;
        ovf_reg <= (ovf_reg & ~reg_wdata[DLCA_ST_OVF +: 2]) |
                   (frm_push & ~frm_ready);
      end else begin
        perr_reg <= perr_reg | bad_par;
        ovf_reg <= ovf_reg | (frm_push & ~frm_ready);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        DLCA_OFS_PORT_CFG: reg_rdata <= port_cfg_reg[reg_port_sel];
        DLCA_OFS_DEV_CTRL: reg_rdata <= dev_ctrl_reg;
        DLCA_OFS_STATUS: reg_rdata <= {2'h0, ovf_reg, perr_reg,
                                       boot_reg == DLCA_RUN, ref_ext_reg};
        DLCA_OFS_VC_MAP0: reg_rdata <= vc_map_reg[0];
        DLCA_OFS_VC_MAP1: reg_rdata <= vc_map_reg[1];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ********************************************************
  // receive ports
  // ********************************************************
  for (genvar p = 0; p < 2; p++) begin : g_rx
    logic c1_reg, c2_reg, c3_reg, d1_reg, d2_reg, f1_reg, f2_reg;
    logic [39:0] sh_reg;
    logic [5:0] cnt_reg;
    logic done_reg;
    logic raw;
    logic [5:0] len;
    logic [9:0] bc_sh_reg;
    logic [3:0] bc_cnt_reg;

    assign raw = dlca_is_raw(port_cfg_reg[p][DLCA_MODE_LSB +: 2]);
    assign len = raw ? DLCA_RAW_FRAME_LEN : DLCA_CSI_FRAME_LEN;

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        {c1_reg, c2_reg, c3_reg} <= 3'h0;
        {d1_reg, d2_reg, f1_reg, f2_reg} <= 4'h0;
      end else begin
        c1_reg <= link_clk[p];
        c2_reg <= c1_reg;
        c3_reg <= c2_reg;
        d1_reg <= link_data[p];
        d2_reg <= d1_reg;
        f1_reg <= link_frame[p];
        f2_reg <= f1_reg;
      end
    end

    // deframer: frame pin marks the msb, which is sent first
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sh_reg <= 40'h0000000000;
        cnt_reg <= 6'h00;
        done_reg <= 1'b0;
      end else begin
        done_reg <= 1'b0;
        if (c2_reg && !c3_reg && (f2_reg || cnt_reg != 6'h00)) begin
          sh_reg <= {sh_reg[38:0], d2_reg};
          if (f2_reg) begin
            cnt_reg <= 6'h01;
          end else if (cnt_reg == len - 6'h01) begin
            cnt_reg <= 6'h00;
            done_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
      end
    end

    // payload bits pass untouched; only the header vc is rewritten
    assign bad_par[p] = done_reg && (raw ? ^sh_reg[27:0] : ^sh_reg);
    assign frm_push[p] = done_reg && !bad_par[p] &&
                         (raw ? sh_reg[26] : sh_reg[32]);
    assign frm_word[p] = raw
      ? {!sh_reg[24], dlca_remap(vc_map_reg[p], 2'h0),
         8'h00, sh_reg[23:0]}
      : {sh_reg[33], dlca_remap(vc_map_reg[p], sh_reg[35:34]),
         sh_reg[31:0]};

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        fwd_ctrl_valid[p] <= 1'b0;
        fwd_ctrl_bits[3*p +: 3] <= 3'h0;
      end else begin
        fwd_ctrl_valid[p] <= done_reg && !bad_par[p] && !raw;
        if (done_reg && !bad_par[p] && !raw)
          fwd_ctrl_bits[3*p +: 3] <= sh_reg[38:36];
      end
    end

    // overflow is flagged: the link itself cannot be stalled
    dlca_buf2 #(.W(DLCA_WORD_W)) u_buf (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(frm_push[p]),
      .in_ready(frm_ready[p]),
      .in_data(frm_word[p]),
      .out_valid(q_valid[p]),
      .out_ready(q_pop[p]),
      .out_data(q_word[p])
    );

    // reverse channel: framed bytes sent back to back, idle or not
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        bc_sh_reg <= 10'h200;
        bc_cnt_reg <= 4'h0;
        pend_reg[p] <= 1'b0;
        pend_byte_reg[p] <= 8'h00;
        relay_ready[p] <= 1'b0;
        link_pair_out[p] <= 1'b0;
        link_pair_oe[p] <= 1'b0;
      end else begin
        relay_ready[p] <= !pend_reg[p] && boot_reg == DLCA_RUN;
        link_pair_oe[p] <= (boot_reg == DLCA_RUN);
        if (bc_tick && boot_reg == DLCA_RUN) begin
          link_pair_out[p] <= bc_sh_reg[9];
          if (bc_cnt_reg == 4'(DLCA_BC_LEN - 1)) begin
            bc_cnt_reg <= 4'h0;
            bc_sh_reg <= {1'b1, pend_reg[p], pend_byte_reg[p]};
            pend_reg[p] <= 1'b0;
          end else begin
            bc_cnt_reg <= bc_cnt_reg + 4'h1;
            bc_sh_reg <= {bc_sh_reg[8:0], 1'b0};
          end
        end
        if (relay_valid && relay_port == p && relay_ready[p]) begin
          relay_ready[p] <= 1'b0;
          pend_reg[p] <= 1'b1;
          pend_byte_reg[p] <= relay_data;
        end
      end
    end
  end

  // ********************************************************
  // merger and csi output
  // ********************************************************
  assign out_free = !tx_valid ||
    (tx_ready && (tx_b_ready || !dev_ctrl_reg[DLCA_CTRL_DUAL]));

  always_comb begin
    case (arb_reg)
      DLCA_ARB_P0: pick = 1'b0;
      DLCA_ARB_P1: pick = 1'b1;
      default: pick = (q_valid[0] && q_valid[1]) ? !last_grant_reg
                                                 : q_valid[1];
    endcase
  end
  assign load = out_free && q_valid[pick];
  assign q_pop = {load && pick, load && !pick};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_reg <= DLCA_ARB_IDLE;
      last_grant_reg <= 1'b1;
    end else if (load) begin
      if (q_word[pick][DLCA_WORD_W-1]) begin
        arb_reg <= DLCA_ARB_IDLE;
        last_grant_reg <= pick;
      end else begin
        arb_reg <= pick ? DLCA_ARB_P1 : DLCA_ARB_P0;
      end
    end
  end

  // lane striping and line rates live in the phy; this is byte level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 32'h00000000;
      tx_vc <= 2'h0;
      tx_last <= 1'b0;
      tx_src_port <= 1'b0;
      tx_b_valid <= 1'b0;
      tx_b_data <= 32'h00000000;
      tx_b_vc <= 2'h0;
      tx_b_last <= 1'b0;
      tx_dual <= 1'b0;
      tx_clk_b_en <= 1'b0;
    end else begin
      tx_dual <= dev_ctrl_reg[DLCA_CTRL_DUAL];
      tx_clk_b_en <= dev_ctrl_reg[DLCA_CTRL_DUAL];
      if (load) begin
        tx_valid <= 1'b1;
        {tx_last, tx_vc, tx_data} <= q_word[pick];
        tx_src_port <= pick;
        tx_b_valid <= dev_ctrl_reg[DLCA_CTRL_DUAL];
        {tx_b_last, tx_b_vc, tx_b_data} <= q_word[pick];
      end else if (out_free) begin
        tx_valid <= 1'b0;
        tx_b_valid <= 1'b0;
      end
    end
  end
endmodule : dlca_top
`default_nettype wire

// ---- test_dual_link_csi_aggregator.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_dual_link_csi_aggregator;
  import dlca_pkg::*;
  logic clk, arst_n, pdr, refc, reg_wr, reg_sel, rly_v, rly_p;
  logic tx_ready, tx_b_ready, tx_valid, tx_last, tx_src, tx_dual, clkb;
  logic [2:0] strap;
  logic [7:0] reg_addr, reg_wdata, rly_d, reg_rdata, map1;
  wire logic [1:0] lclk, ldat, lfrm;
  logic [1:0] oe, pout, rly_rdy, fcv, tx_vc;
  logic [5:0] fcb;
  logic [31:0] tx_data;
  int fails = 0, n_tests = 0, cyc = 0;
  dlca_ser_model i_ser0 (.lclk(lclk[0]), .ldat(ldat[0]), .lfrm(lfrm[0]));
  dlca_ser_model i_ser1 (.lclk(lclk[1]), .ldat(ldat[1]), .lfrm(lfrm[1]));
  dlca_top #(.STRAP_WAIT(20), .REF_LOSS(50)) i_dut (
    .clk(clk), .arst_n(arst_n), .power_down_release_pin(pdr),
    .mode_strap(strap), .ref_clock_input(refc), .link_clk(lclk),
    .link_data(ldat), .link_frame(lfrm), .link_pair_out(pout),
    .link_pair_oe(oe), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_port_sel(reg_sel), .reg_rdata(reg_rdata),
    .relay_valid(rly_v), .relay_port(rly_p), .relay_data(rly_d),
    .relay_ready(rly_rdy), .fwd_ctrl_valid(fcv), .fwd_ctrl_bits(fcb),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_vc(tx_vc), .tx_last(tx_last), .tx_src_port(tx_src),
    .tx_dual(tx_dual), .tx_clk_b_en(clkb), .tx_b_valid(),
    .tx_b_ready(tx_b_ready), .tx_b_data(), .tx_b_vc(), .tx_b_last());
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    refc = 1'b0;
    forever #20 refc = ~refc;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic boot();
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    pdr <= 1'b1;
    do begin
      @(posedge clk);
      #1 n++;
    end while (oe !== 2'b11 && n < 500);
    chk(oe, 2'b11);
  endtask : boot
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_sel <= s;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic s, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_sel <= s;
    repeat (2) @(posedge clk);
    #1 v = reg_rdata;
  endtask : rd
  task automatic snd(input logic p, input logic [39:0] w, input int len);
    if (p) i_ser1.send(w, len);
    else i_ser0.send(w, len);
  endtask : snd
  task automatic get(input logic [31:0] d, input logic [1:0] v,
                     input logic l, input logic p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tx_valid !== 1'b1 && n < 2000);
    chk(tx_valid, 1'b1);
    chk(tx_data, d);
    chk(tx_vc, v);
    chk(tx_last, l);
    chk(tx_src, p);
    repeat ($urandom_range(1, 4)) @(posedge clk);
    tx_ready <= 1'b1;
    tx_b_ready <= 1'b1;
    @(posedge clk);
    tx_ready <= 1'b0;
    tx_b_ready <= 1'b0;
  endtask : get
  function automatic logic [39:0] mk_csi(input logic [1:0] v,
      input logic l, input logic ok, input logic [31:0] d);
    logic [39:0] w;
    w = {1'b0, 3'h5, v, l, ok, d};
    w[39] = ^w[38:0];
    return w;
  endfunction : mk_csi
  function automatic logic [39:0] mk_raw(input logic [23:0] d);
    logic [39:0] w;
    w = {12'h000, 1'b0, 1'b1, 1'b1, 1'b0, d};
    w[27] = ^w[26:0];
    return w;
  endfunction : mk_raw
  initial begin
    logic [31:0] d;
    logic [7:0] r;
    logic [1:0] v;
    logic l, p;
    int k;
    {arst_n, pdr, reg_wr, reg_sel, rly_v, rly_p} = 6'h00;
    {tx_ready, tx_b_ready, strap, reg_addr, reg_wdata, rly_d} = 29'h0;
    k = $urandom(68);
    boot();
    rd(DLCA_OFS_PORT_CFG, 1'b0, r);
    chk(r, DLCA_PORT_CFG_RST);
    rd(DLCA_OFS_VC_MAP1, 1'b0, r);
    chk(r, DLCA_VC_MAP1_RST);
    rd(8'h55, 1'b0, r);
    chk(r, 8'h00);
    rd(DLCA_OFS_STATUS, 1'b0, r);
    chk(r & 8'h03, 8'h03);
    d = $urandom;
    wr(DLCA_OFS_PORT_CFG, d[7:0], 1'b1);
    rd(DLCA_OFS_PORT_CFG, 1'b1, r);
    chk(r, d[7:0]);
    wr(DLCA_OFS_PORT_CFG, 8'h00, 1'b1);
    $display("registers done");
    map1 = $urandom;
    wr(DLCA_OFS_VC_MAP1, map1, 1'b0);
    for (k = 0; k < 6; k++) begin
      if (k == 3) begin
        wr(DLCA_OFS_DEV_CTRL, 8'h01, 1'b0);
        #1 chk(clkb, 1'b1);
      end
      {l, v, d} = {$urandom, $urandom};
      p = k[1];
      l |= k[0];
      snd(p, mk_csi(v, l, 1'b1, d), 40);
      get(d, p ? map1[2*v +: 2] : v, l, p);
    end
    $display("csi forward done");
    snd(0, mk_csi(2'h0, 1'b1, 1'b1, d) ^ 40'h1, 40);
    snd(0, mk_csi(2'h2, 1'b1, 1'b0, d), 40);
    snd(0, mk_csi(2'h1, 1'b1, 1'b1, ~d), 40);
    get(~d, 2'h1, 1'b1, 1'b0);
    chk(fcb[2:0], 3'h5);
    rd(DLCA_OFS_STATUS, 1'b0, r);
    chk(r & 8'h04, 8'h04);
    wr(DLCA_OFS_STATUS, 8'h04, 1'b0);
    rd(DLCA_OFS_STATUS, 1'b0, r);
    chk(r & 8'h04, 8'h00);
    for (k = 1; k < 4; k++) begin
      wr(DLCA_OFS_PORT_CFG, k[7:0], 1'b1);
      d = $urandom;
      snd(1, mk_raw(d[23:0]), 28);
      get({8'h00, d[23:0]}, map1[1:0], 1'b1, 1'b1);
    end
    $display("raw modes done");
    for (k = 0; k < 5; k++) snd(0, mk_csi(2'h0, 1'b1, 1'b1, k), 40);
    rd(DLCA_OFS_STATUS, 1'b0, r);
    chk(r & 8'h10, 8'h10);
    get(32'h0, 2'h0, 1'b1, 1'b0);
    @(posedge clk);
    {tx_ready, tx_b_ready} <= 2'b11;
    repeat (12) @(posedge clk);
    {tx_ready, tx_b_ready} <= 2'b00;
    #1 chk(tx_valid, 1'b0);
    $display("overflow done");
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      rly_v <= 1'b1;
      rly_p <= k[0];
      rly_d <= $urandom;
      @(posedge clk);
      rly_v <= 1'b0;
      d = 0;
      do begin
        @(posedge clk);
        #1 d++;
      end while (rly_rdy[k] !== 1'b1 && d < 1000);
      chk(rly_rdy[k], 1'b1);
    end
    $display("relay done");
    arst_n <= 1'b0;
    boot();
    tally_and_finish();
  end
endmodule : test_dual_link_csi_aggregator
`default_nettype wire
